// file: rtl/agrc_consts.vh
// Constants shared by the gain, coding and reference-detect control block
`ifndef AGRC_CONSTS_VH
`define AGRC_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define AGRC_OFF_CONFIG 12'h000
`define AGRC_OFF_CAL_CTRL 12'h004
`define AGRC_OFF_STATUS 12'h008
`define AGRC_OFF_INT_STATUS 12'h00C
`define AGRC_OFF_INT_MASK 12'h010
`define AGRC_OFF_RESULT 12'h014
`define AGRC_OFF_OFFSET_COEF 12'h018
`define AGRC_OFF_FULLSCALE_COEF 12'h01C

// ****************************************
// Configuration register fields
// ****************************************
`define AGRC_CFG_GAIN_LSB 0
`define AGRC_CFG_GAIN_MSB 2
`define AGRC_CFG_BUF_BIT 4
`define AGRC_CFG_UNIPOLAR_BIT 8
`define AGRC_CFG_BURNOUT_BIT 12
`define AGRC_CFG_REFCHK_BIT 16

// ****************************************
// Configuration reset values
// ****************************************
`define AGRC_RST_GAIN 3'h0
`define AGRC_RST_BUF 1'h1
`define AGRC_RST_UNIPOLAR 1'h0
`define AGRC_RST_BURNOUT 1'h0
`define AGRC_RST_REFCHK 1'h0

// ****************************************
// Gain codes and calibration commands
// ****************************************
`define AGRC_GAIN_CODE_2 3'h1
`define AGRC_GAIN_CODE_4 3'h2
`define AGRC_CAL_NONE 2'h0
`define AGRC_CAL_OFFSET 2'h1
`define AGRC_CAL_FULLSCALE 2'h2

// ****************************************
// Status and interrupt bit positions
// ****************************************
`define AGRC_ST_REFMISS_BIT 0
`define AGRC_ST_ERR_BIT 1
`define AGRC_ST_CALBUSY_BIT 2
`define AGRC_ST_READY_BIT 3
`define AGRC_ST_COMMWAIT_BIT 4
`define AGRC_INT_CONV_BIT 0
`define AGRC_INT_REFMISS_BIT 1
`define AGRC_INT_CALERR_BIT 2
`define AGRC_INT_CALDONE_BIT 3
`define AGRC_INT_W 4

// ****************************************
// Timing
// ****************************************
`define AGRC_PCLK_MHZ 200
`define AGRC_T_HOLDOFF_US 500
`define AGRC_HOLDOFF_CYCLES (`AGRC_T_HOLDOFF_US * `AGRC_PCLK_MHZ)
`define AGRC_SER_RESET_ONES 32
`define AGRC_CAL_CONVS 2

`endif

// file: rtl/agrc_ctrl.v
// Gain, output coding, burnout and reference-detect control with APB registers
`timescale 1ns/1ps
`include "agrc_consts.vh"
module agrc_ctrl #(
  parameter RESULT_W = 24,
  parameter HOLDOFF_CYCLES = `AGRC_HOLDOFF_CYCLES,
  parameter CAL_CONVS = `AGRC_CAL_CONVS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Serial link pins
  input wire sclk,
  input wire din,
  // Reference comparator pins
  input wire ref_below_threshold,
  input wire ref_open,
  // Modulator and filter result
  input wire raw_valid,
  input wire [RESULT_W-1:0] raw_result,
  // Analog front-end controls
  output reg [2:0] gain_select,
  output reg [7:0] gain_value,
  output reg input_buffer_enable,
  output reg inamp_enable,
  output reg burnout_source_enable,
  output reg burnout_sink_enable,
  output reg reference_check_enable,
  output reg core_reset,
  // Results and coefficients
  output reg [RESULT_W-1:0] result_data,
  output reg result_valid,
  output reg [RESULT_W-1:0] offset_coef,
  output reg [RESULT_W-1:0] fullscale_coef,
  output reg reference_missing_flag,
  // Interrupt
  output wire irq
);

// ****************************************
// Serial reset watcher
// ****************************************
wire serial_reset_pulse;
wire comm_wait;
wire soft_rst;

agrc_serial_reset #(
  .ONES(`AGRC_SER_RESET_ONES)
) u_serial_reset (
  .pclk(pclk),
  .presetn(presetn),
  .sclk(sclk),
  .din(din),
  .serial_reset_pulse(serial_reset_pulse),
  .comm_wait_reg(comm_wait)
);

assign soft_rst = serial_reset_pulse;

// ****************************************
// Reference pin synchronisers
// ****************************************
reg [1:0] ref_low_sync_reg;
reg [1:0] ref_open_sync_reg;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ref_low_sync_reg <= 2'h0;
    ref_open_sync_reg <= 2'h0;
  end else begin
    ref_low_sync_reg <= {ref_low_sync_reg[0], ref_below_threshold};
    ref_open_sync_reg <= {ref_open_sync_reg[0], ref_open};
  end
end

// ****************************************
// APB decode
// ****************************************
wire wr_en;
wire rd_en;
wire addr_hit;
reg [31:0] rdata_next;

assign pready = 1'b1;
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & penable & ~pwrite;
assign addr_hit = (paddr == `AGRC_OFF_CONFIG) || (paddr == `AGRC_OFF_CAL_CTRL) ||
                  (paddr == `AGRC_OFF_STATUS) || (paddr == `AGRC_OFF_INT_STATUS) ||
                  (paddr == `AGRC_OFF_INT_MASK) || (paddr == `AGRC_OFF_RESULT) ||
                  (paddr == `AGRC_OFF_OFFSET_COEF) || (paddr == `AGRC_OFF_FULLSCALE_COEF);

// ****************************************
// Configuration register
// ****************************************
reg [2:0] cfg_gain_reg;
reg cfg_buf_reg;
reg cfg_unipolar_reg;
reg cfg_burnout_reg;
reg cfg_refchk_reg;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cfg_gain_reg <= `AGRC_RST_GAIN;
    cfg_buf_reg <= `AGRC_RST_BUF;
    cfg_unipolar_reg <= `AGRC_RST_UNIPOLAR;
    cfg_burnout_reg <= `AGRC_RST_BURNOUT;
    cfg_refchk_reg <= `AGRC_RST_REFCHK;
  end else if (soft_rst) begin
    cfg_gain_reg <= `AGRC_RST_GAIN;
    cfg_buf_reg <= `AGRC_RST_BUF;
    cfg_unipolar_reg <= `AGRC_RST_UNIPOLAR;
    cfg_burnout_reg <= `AGRC_RST_BURNOUT;
    cfg_refchk_reg <= `AGRC_RST_REFCHK;
  end else if (wr_en && paddr == `AGRC_OFF_CONFIG) begin
    cfg_gain_reg <= pwdata[`AGRC_CFG_GAIN_MSB:`AGRC_CFG_GAIN_LSB];
    cfg_buf_reg <= pwdata[`AGRC_CFG_BUF_BIT];
    cfg_unipolar_reg <= pwdata[`AGRC_CFG_UNIPOLAR_BIT];
    cfg_burnout_reg <= pwdata[`AGRC_CFG_BURNOUT_BIT];
    cfg_refchk_reg <= pwdata[`AGRC_CFG_REFCHK_BIT];
  end
end

// ****************************************
// Front-end control outputs
// ****************************************
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    gain_select <= 3'h0;
    gain_value <= 8'h01;
    input_buffer_enable <= 1'h1;
    inamp_enable <= 1'h0;
    burnout_source_enable <= 1'h0;
    burnout_sink_enable <= 1'h0;
    reference_check_enable <= 1'h0;
    core_reset <= 1'h1;
  end else begin
    gain_select <= cfg_gain_reg;
    gain_value <= 8'h01 << cfg_gain_reg;
    input_buffer_enable <= cfg_buf_reg | (cfg_gain_reg > `AGRC_GAIN_CODE_2);
    inamp_enable <= (cfg_gain_reg >= `AGRC_GAIN_CODE_4);
    burnout_source_enable <= cfg_burnout_reg;
    burnout_sink_enable <= cfg_burnout_reg;
    reference_check_enable <= cfg_refchk_reg;
    core_reset <= soft_rst;
  end
end

// ****************************************
// Reference detection
// ****************************************
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    reference_missing_flag <= 1'h0;
  end else if (soft_rst) begin
    reference_missing_flag <= 1'h0;
  end else begin
    reference_missing_flag <= cfg_refchk_reg & (ref_low_sync_reg[1] | ref_open_sync_reg[1]);
  end
end

// ****************************************
// Calibration sequencer
// ****************************************
localparam CAL_IDLE = 2'h0;
localparam CAL_RUN = 2'h1;
localparam CAL_END = 2'h2;

reg [1:0] cal_state_reg;
reg [1:0] cal_kind_reg;
reg [3:0] cal_count_reg;
reg cal_refbad_reg;
reg [RESULT_W-1:0] cal_sample_reg;
reg cal_done_pulse;
reg cal_err_pulse;
wire cal_start;

assign cal_start = wr_en && (paddr == `AGRC_OFF_CAL_CTRL) &&
                   (pwdata[1:0] == `AGRC_CAL_OFFSET || pwdata[1:0] == `AGRC_CAL_FULLSCALE);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    cal_state_reg <= CAL_IDLE;
    cal_kind_reg <= `AGRC_CAL_NONE;
    cal_count_reg <= 4'h0;
    cal_refbad_reg <= 1'h0;
    cal_sample_reg <= {RESULT_W{1'b0}};
    offset_coef <= {RESULT_W{1'b0}};
    fullscale_coef <= {RESULT_W{1'b0}};
    cal_done_pulse <= 1'h0;
    cal_err_pulse <= 1'h0;
  end else if (soft_rst) begin
    cal_state_reg <= CAL_IDLE;
    cal_kind_reg <= `AGRC_CAL_NONE;
    cal_count_reg <= 4'h0;
    cal_refbad_reg <= 1'h0;
    cal_sample_reg <= {RESULT_W{1'b0}};
    offset_coef <= {RESULT_W{1'b0}};
    fullscale_coef <= {RESULT_W{1'b0}};
    cal_done_pulse <= 1'h0;
    cal_err_pulse <= 1'h0;
  end else begin
    cal_done_pulse <= 1'h0;
    cal_err_pulse <= 1'h0;
    case (cal_state_reg)
      CAL_IDLE: begin
        if (cal_start) begin
          cal_kind_reg <= pwdata[1:0];
          cal_count_reg <= 4'h0;
          cal_refbad_reg <= 1'h0;
          cal_state_reg <= CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (reference_missing_flag) begin
          cal_refbad_reg <= 1'h1;
        end
        if (raw_valid) begin
          cal_sample_reg <= raw_result;
          if (cal_count_reg == CAL_CONVS[3:0] - 4'h1) begin
            cal_state_reg <= CAL_END;
          end else begin
            cal_count_reg <= cal_count_reg + 4'h1;
          end
        end
      end
      CAL_END: begin
        if (cal_refbad_reg || reference_missing_flag) begin
          cal_err_pulse <= 1'h1;
        end else if (cal_kind_reg == `AGRC_CAL_OFFSET) begin
          offset_coef <= cal_sample_reg;
        end else begin
          fullscale_coef <= cal_sample_reg;
        end
        cal_done_pulse <= 1'h1;
        cal_kind_reg <= `AGRC_CAL_NONE;
        cal_state_reg <= CAL_IDLE;
      end
      default: begin
        cal_state_reg <= CAL_IDLE;
      end
    endcase
  end
end

// ****************************************
// Output coding
// ****************************************
reg [RESULT_W-1:0] coded_next;
wire [RESULT_W-1:0] msb_only;

assign msb_only = {1'b1, {(RESULT_W-1){1'b0}}};

always @* begin
  coded_next = raw_result ^ msb_only;
  if (cfg_unipolar_reg) begin
    if (raw_result[RESULT_W-1]) begin
      coded_next = {RESULT_W{1'b0}};
    end else if (&raw_result[RESULT_W-2:0]) begin
      coded_next = {RESULT_W{1'b1}};
    end else begin
      coded_next = {raw_result[RESULT_W-2:0], 1'b0};
    end
  end
  if (reference_missing_flag) begin
    coded_next = {RESULT_W{1'b1}};
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    result_data <= {RESULT_W{1'b0}};
    result_valid <= 1'h0;
  end else if (soft_rst) begin
    result_data <= {RESULT_W{1'b0}};
    result_valid <= 1'h0;
  end else begin
    result_valid <= raw_valid && (cal_state_reg == CAL_IDLE);
    if (raw_valid && cal_state_reg == CAL_IDLE) begin
      result_data <= coded_next;
    end
  end
end

// ****************************************
// Access hold-off after reset
// ****************************************
reg [16:0] holdoff_count_reg;
reg access_ready_reg;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    holdoff_count_reg <= 17'h00000;
    access_ready_reg <= 1'h0;
  end else if (soft_rst) begin
    holdoff_count_reg <= 17'h00000;
    access_ready_reg <= 1'h0;
  end else if (!access_ready_reg) begin
    if (holdoff_count_reg == HOLDOFF_CYCLES[16:0] - 17'h00001) begin
      access_ready_reg <= 1'h1;
    end else begin
      holdoff_count_reg <= holdoff_count_reg + 17'h00001;
    end
  end
end

// ****************************************
// Interrupt status and mask
// ****************************************
reg [`AGRC_INT_W-1:0] int_status_reg;
reg [`AGRC_INT_W-1:0] int_mask_reg;
reg refmiss_prev_reg;
reg err_flag_reg;
wire [`AGRC_INT_W-1:0] int_set;
wire [`AGRC_INT_W-1:0] int_clr;

assign int_set = {cal_done_pulse, cal_err_pulse, reference_missing_flag & ~refmiss_prev_reg,
                  raw_valid & (cal_state_reg == CAL_IDLE)};
assign int_clr = (wr_en && paddr == `AGRC_OFF_INT_STATUS) ? pwdata[`AGRC_INT_W-1:0] : {`AGRC_INT_W{1'b0}};
assign irq = |(int_status_reg & int_mask_reg);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    int_status_reg <= {`AGRC_INT_W{1'b0}};
    int_mask_reg <= {`AGRC_INT_W{1'b0}};
    refmiss_prev_reg <= 1'h0;
    err_flag_reg <= 1'h0;
  end else if (soft_rst) begin
    int_status_reg <= {`AGRC_INT_W{1'b0}};
    int_mask_reg <= {`AGRC_INT_W{1'b0}};
    refmiss_prev_reg <= 1'h0;
    err_flag_reg <= 1'h0;
  end else begin
    refmiss_prev_reg <= reference_missing_flag;
    int_status_reg <= (int_status_reg & ~int_clr) | int_set;
    if (wr_en && paddr == `AGRC_OFF_INT_MASK) begin
      int_mask_reg <= pwdata[`AGRC_INT_W-1:0];
    end
    if (cal_err_pulse) begin
      err_flag_reg <= 1'h1;
    end else if (cal_start) begin
      err_flag_reg <= 1'h0;
    end
  end
end

// ****************************************
// Read data
// ****************************************
always @* begin
  rdata_next = 32'h00000000;
  case (paddr)
    `AGRC_OFF_CONFIG: begin
      rdata_next[`AGRC_CFG_GAIN_MSB:`AGRC_CFG_GAIN_LSB] = cfg_gain_reg;
      rdata_next[`AGRC_CFG_BUF_BIT] = cfg_buf_reg;
      rdata_next[`AGRC_CFG_UNIPOLAR_BIT] = cfg_unipolar_reg;
      rdata_next[`AGRC_CFG_BURNOUT_BIT] = cfg_burnout_reg;
      rdata_next[`AGRC_CFG_REFCHK_BIT] = cfg_refchk_reg;
    end
    `AGRC_OFF_CAL_CTRL: begin
      rdata_next[1:0] = cal_kind_reg;
    end
    `AGRC_OFF_STATUS: begin
      rdata_next[`AGRC_ST_REFMISS_BIT] = reference_missing_flag;
      rdata_next[`AGRC_ST_ERR_BIT] = err_flag_reg;
      rdata_next[`AGRC_ST_CALBUSY_BIT] = (cal_state_reg != CAL_IDLE);
      rdata_next[`AGRC_ST_READY_BIT] = access_ready_reg;
      rdata_next[`AGRC_ST_COMMWAIT_BIT] = comm_wait;
    end
    `AGRC_OFF_INT_STATUS: begin
      rdata_next[`AGRC_INT_W-1:0] = int_status_reg;
    end
    `AGRC_OFF_INT_MASK: begin
      rdata_next[`AGRC_INT_W-1:0] = int_mask_reg;
    end
    `AGRC_OFF_RESULT: begin
      rdata_next[RESULT_W-1:0] = result_data;
    end
    `AGRC_OFF_OFFSET_COEF: begin
      rdata_next[RESULT_W-1:0] = offset_coef;
    end
    `AGRC_OFF_FULLSCALE_COEF: begin
      rdata_next[RESULT_W-1:0] = fullscale_coef;
    end
    default: begin
      rdata_next = 32'h00000000;
    end
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
    pslverr <= 1'h0;
  end else begin
    pslverr <= psel & ~penable & ~addr_hit;
    if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end
end

endmodule

// file: rtl/agrc_serial_reset.v
// Serial link watcher: finds clock edges, counts ones, flags reset
`timescale 1ns/1ps
`include "agrc_consts.vh"
module agrc_serial_reset #(
  parameter ONES = `AGRC_SER_RESET_ONES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Serial pins
  input wire sclk,
  input wire din,
  // Results
  output reg serial_reset_pulse,
  output reg comm_wait_reg
);

// ****************************************
// Synchronisers
// ****************************************
reg [1:0] sclk_sync_reg;
reg [1:0] din_sync_reg;
reg sclk_prev_reg;
reg [5:0] ones_count_reg;
wire sclk_rise;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    sclk_sync_reg <= 2'h3;
    din_sync_reg <= 2'h0;
    sclk_prev_reg <= 1'h1;
  end else begin
    sclk_sync_reg <= {sclk_sync_reg[0], sclk};
    din_sync_reg <= {din_sync_reg[0], din};
    sclk_prev_reg <= sclk_sync_reg[1];
  end
end

assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;

// ****************************************
// Consecutive ones counter
// ****************************************
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ones_count_reg <= 6'h00;
    serial_reset_pulse <= 1'h0;
    comm_wait_reg <= 1'h1;
  end else begin
    serial_reset_pulse <= 1'h0;
    if (sclk_rise) begin
      if (!din_sync_reg[1]) begin
        ones_count_reg <= 6'h00;
        comm_wait_reg <= 1'h0;
      end else if (ones_count_reg == ONES[5:0] - 6'h01) begin
        ones_count_reg <= 6'h00;
        serial_reset_pulse <= 1'h1;
        comm_wait_reg <= 1'h1;
      end else begin
        ones_count_reg <= ones_count_reg + 6'h01;
      end
    end
  end
end

endmodule

// file: testbench/adc_gain_coding_refdetect_ctrl_tb.sv
// Self-checking bench for the gain, coding and reference-detect control block
`timescale 1ns/1ps
`include "agrc_consts.vh"
module adc_gain_coding_refdetect_ctrl_tb;
  localparam HOLD = 20;
  reg pclk, presetn, psel, penable, pwrite, ref_below_threshold, ref_open, raw_valid, last_err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [23:0] raw_result, res;
  reg [78:0] rows [0:7];
  wire [31:0] prdata;
  wire pready, pslverr, sclk, din, input_buffer_enable, inamp_enable, burnout_source_enable;
  wire burnout_sink_enable, reference_check_enable, core_reset, result_valid, reference_missing_flag, irq;
  wire [2:0] gain_select;
  wire [7:0] gain_value;
  wire [23:0] result_data, offset_coef, fullscale_coef;
  integer failures, compares, cr_seen, i;
  agrc_ctrl #(.RESULT_W(24), .HOLDOFF_CYCLES(HOLD), .CAL_CONVS(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .din(din), .ref_below_threshold(ref_below_threshold),
    .ref_open(ref_open), .raw_valid(raw_valid), .raw_result(raw_result), .gain_select(gain_select),
    .gain_value(gain_value), .input_buffer_enable(input_buffer_enable), .inamp_enable(inamp_enable),
    .burnout_source_enable(burnout_source_enable), .burnout_sink_enable(burnout_sink_enable),
    .reference_check_enable(reference_check_enable), .core_reset(core_reset), .result_data(result_data),
    .result_valid(result_valid), .offset_coef(offset_coef), .fullscale_coef(fullscale_coef),
    .reference_missing_flag(reference_missing_flag), .irq(irq));
  agrc_host_model host (.sclk(sclk), .din(din));
  // ****************************************
  // Clock, watchdog, helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #300000;
    failures = failures + 1;
    $display("watchdog expired");
    tally_and_finish;
  end
  always @(posedge pclk) if (core_reset === 1'b1 && presetn) cr_seen <= cr_seen + 1;
  task tally_and_finish;
    begin
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input reg w, input [11:0] a, input [31:0] d, output [31:0] r);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task conv(input [23:0] v, output [23:0] r);
    integer n;
    begin
      raw_result <= v;
      raw_valid <= 1'b1;
      @(posedge pclk);
      raw_valid <= 1'b0;
      @(posedge pclk);
      n = 0;
      while (result_valid !== 1'b1 && n < 4) begin
        @(posedge pclk);
        n = n + 1;
      end
      r = (result_valid === 1'b1) ? result_data : {24{1'bx}};
    end
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    failures = 0;
    compares = 0;
    cr_seen = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ref_below_threshold = 1'b0;
    ref_open = 1'b0;
    raw_valid = 1'b0;
    raw_result = 24'h000000;
    // Rows: config, raw, coded result, gain value, {buffer, inamp, burnout}
    rows[0] = {20'h00000, 24'h000000, 24'h800000, 8'h01, 3'b000};
    rows[1] = {20'h01001, 24'h800000, 24'h000000, 8'h02, 3'b001};
    rows[2] = {20'h00002, 24'h7FFFFF, 24'hFFFFFF, 8'h04, 3'b110};
    rows[3] = {20'h00103, 24'h000000, 24'h000000, 8'h08, 3'b110};
    rows[4] = {20'h00104, 24'h400000, 24'h800000, 8'h10, 3'b110};
    rows[5] = {20'h00105, 24'h7FFFFF, 24'hFFFFFF, 8'h20, 3'b110};
    rows[6] = {20'h00106, 24'hFFFFFF, 24'h000000, 8'h40, 3'b110};
    rows[7] = {20'h00017, 24'h000001, 24'h800001, 8'h80, 3'b110};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `AGRC_OFF_CONFIG, 32'h0, rd);
    chk("cfg_reset", rd, 32'h00000010);
    apb(1'b0, `AGRC_OFF_STATUS, 32'h0, rd);
    chk("ready_early", 32'(rd[3]), 32'h0);
    chk("comm_wait0", 32'(rd[4]), 32'h1);
    repeat (HOLD) @(posedge pclk);
    apb(1'b0, `AGRC_OFF_STATUS, 32'h0, rd);
    chk("ready_late", 32'(rd[3]), 32'h1);
    apb(1'b0, 12'h020, 32'h0, rd);
    chk("unmapped", {rd[30:0], last_err}, 32'h00000001);
    $display("reset tests done");
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, `AGRC_OFF_CONFIG, 32'(rows[i][78:59]), rd);
      conv(rows[i][58:35], res);
      chk("result", 32'(res), 32'(rows[i][34:11]));
      chk("gain_select", 32'(gain_select), 32'(rows[i][61:59]));
      chk("gain_value", 32'(gain_value), 32'(rows[i][10:3]));
      chk("fe_enables", 32'({input_buffer_enable, inamp_enable, burnout_source_enable, burnout_sink_enable}),
        32'({rows[i][2:0], rows[i][0]}));
    end
    $display("table tests done");
    apb(1'b1, `AGRC_OFF_INT_STATUS, 32'h0000000F, rd);
    apb(1'b1, `AGRC_OFF_INT_MASK, 32'h00000002, rd);
    ref_open <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("flag_off", 32'(reference_missing_flag), 32'h0);
    chk("irq_quiet", 32'(irq), 32'h0);
    apb(1'b1, `AGRC_OFF_CONFIG, 32'h00010000, rd);
    repeat (6) @(posedge pclk);
    chk("flag_on", 32'(reference_missing_flag), 32'h1);
    chk("refchk_en", 32'(reference_check_enable), 32'h1);
    chk("irq_raised", 32'(irq), 32'h1);
    ref_open <= 1'b0;
    ref_below_threshold <= 1'b1;
    conv(24'h000000, res);
    chk("forced_ones", 32'(res), 32'h00FFFFFF);
    apb(1'b1, `AGRC_OFF_CAL_CTRL, 32'(`AGRC_CAL_OFFSET), rd);
    conv(24'h000123, res);
    conv(24'h000456, res);
    repeat (4) @(posedge pclk);
    apb(1'b0, `AGRC_OFF_STATUS, 32'h0, rd);
    chk("cal_err", 32'(rd[1:0]), 32'h3);
    chk("offset_kept", 32'(offset_coef), 32'h0);
    apb(1'b1, `AGRC_OFF_INT_MASK, 32'h0, rd);
    chk("irq_masked", 32'(irq), 32'h0);
    ref_below_threshold <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, `AGRC_OFF_INT_STATUS, 32'h0000000F, rd);
    apb(1'b0, `AGRC_OFF_INT_STATUS, 32'h0, rd);
    chk("int_cleared", rd, 32'h0);
    apb(1'b1, `AGRC_OFF_CAL_CTRL, 32'(`AGRC_CAL_FULLSCALE), rd);
    conv(24'h111111, res);
    conv(24'h123456, res);
    repeat (4) @(posedge pclk);
    chk("fs_updated", 32'(fullscale_coef), 32'h00123456);
    $display("reference tests done");
    apb(1'b1, `AGRC_OFF_CONFIG, 32'h00011007, rd);
    cr_seen = 0;
    host.send(31, 1'b1);
    host.send(1, 1'b0);
    repeat (10) @(posedge pclk);
    chk("no_reset", 32'(cr_seen), 32'h0);
    host.send(32, 1'b1);
    repeat (10) @(posedge pclk);
    chk("soft_reset", 32'(cr_seen), 32'h1);
    repeat (HOLD) @(posedge pclk);
    apb(1'b0, `AGRC_OFF_CONFIG, 32'h0, rd);
    chk("cfg_default", rd, 32'h00000010);
    apb(1'b0, `AGRC_OFF_STATUS, 32'h0, rd);
    chk("comm_wait", 32'(rd[4]), 32'h1);
    $display("serial reset tests done");
    tally_and_finish;
  end
endmodule

// file: testbench/agrc_ctrl_monitor.sv
// Assertion checker for the gain, coding and reference-detect control block
`timescale 1ns/1ps
module agrc_ctrl_monitor #(
  parameter RESULT_W = 24
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  // Reference pin
  input wire ref_open,
  // Watched outputs
  input wire [2:0] gain_select,
  input wire [7:0] gain_value,
  input wire input_buffer_enable,
  input wire inamp_enable,
  input wire burnout_source_enable,
  input wire burnout_sink_enable,
  input wire reference_check_enable,
  input wire core_reset,
  input wire [RESULT_W-1:0] result_data,
  input wire result_valid,
  input wire reference_missing_flag
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_buf_forced; gain_select > 3'h1 |-> input_buffer_enable; endproperty
  a_buf_forced: assert property (p_buf_forced) else $error("buffer off at high gain");
  property p_inamp; inamp_enable == (gain_select >= 3'h2); endproperty
  a_inamp: assert property (p_inamp) else $error("inamp enable wrong for gain");
  property p_gain_value; gain_value == (8'h01 << gain_select); endproperty
  a_gain_value: assert property (p_gain_value) else $error("gain value wrong for code");
  property p_burnout_pair; burnout_source_enable == burnout_sink_enable; endproperty
  a_burnout_pair: assert property (p_burnout_pair) else $error("burnout currents differ");
  property p_check_off; !reference_check_enable && $past(!reference_check_enable) |-> !reference_missing_flag; endproperty
  a_check_off: assert property (p_check_off) else $error("flag set with detection off");
  property p_flag_set; (reference_check_enable && ref_open) [*5] |-> reference_missing_flag; endproperty
  a_flag_set: assert property (p_flag_set) else $error("open reference not flagged");
  property p_forced_ones; result_valid && $past(reference_missing_flag) |-> result_data == {RESULT_W{1'b1}}; endproperty
  a_forced_ones: assert property (p_forced_ones) else $error("result not all ones");
  property p_reset_pulse; $rose(core_reset) |=> !core_reset; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("core reset longer than one cycle");
  property p_reset_defaults;
    core_reset |-> ##[0:2] (gain_select == 3'h0 && input_buffer_enable && !burnout_source_enable
      && !reference_check_enable);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored");
  property p_unmapped; psel && penable && !pwrite && paddr > 12'h01C |-> pslverr && prdata == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule

bind agrc_ctrl agrc_ctrl_monitor #(.RESULT_W(RESULT_W)) u_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .ref_open(ref_open), .gain_select(gain_select), .gain_value(gain_value),
  .input_buffer_enable(input_buffer_enable), .inamp_enable(inamp_enable),
  .burnout_source_enable(burnout_source_enable), .burnout_sink_enable(burnout_sink_enable),
  .reference_check_enable(reference_check_enable), .core_reset(core_reset), .result_data(result_data),
  .result_valid(result_valid), .reference_missing_flag(reference_missing_flag));

// file: testbench/agrc_host_model.sv
// Host model driving frames on the serial link pins
`timescale 1ns/1ps
module agrc_host_model (
  // Serial pins
  output reg sclk,
  output reg din
);
  initial begin
    sclk = 1'b1;
    din = 1'b0;
  end
  // Frame of n equal bits, clock idles high between frames
  task send(input integer n, input reg val);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        din = val;
        sclk = 1'b0;
        #62.5;
        sclk = 1'b1;
        #62.5;
      end
      din = ~val;
    end
  endtask
endmodule
